// file: design/light_adc_core.sv
/*
 Two-channel integrating light sensor core: integration timing on the
 oscillator clock, result handover and byte registers on mclk.
 Assumes comparator pulses and bus pins arrive asynchronously.
*/
// Behaviour
// - Period is 11, 81 or 322 times 918 oscillator cycles by field code.
// - Count at most every second cycle, minus two counts of offset.
// - Each result saturates at 65535.
// - Both channels integrate over one shared period.
// - Results reach readable registers through a double buffer.
// - Except in manual mode, next period starts right after the transfer.
// - Bus address follows the three-level select pin.
// - Direction bit 1 means the device sends data.
// - Written byte with MSB set is a command byte.
// - Command low four bits become the register pointer.
// - Reads return the register the pointer selects.
// - Send byte is start, address, write, ack, data, ack, stop.
// - Command bit 6 is ignored, as there is no interrupt logic; bit 5 marks word access.
// - Timing register at 1h holds field in bits 1:0, resets to 02h.
// - Results sit at Ch to Fh, broadband low/high then infrared low/high.
// - Writing 03h to power register powers up and reads back 03h.
`timescale 1ns/1ps
`default_nettype none
module light_adc_core #(
    parameter int unsigned PERIOD_UNIT = light_adc_pkg::PERIOD_UNIT
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic osc_clk,
    input wire logic broadband_pulse,
    input wire logic infrared_pulse,
    input wire logic [1:0] addr_sel,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic powered
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic en);
        sat_inc = (en && v != light_adc_pkg::COUNT_MAX) ? v + 16'h0001 : v;
    endfunction : sat_inc

    function automatic logic [18:0] period_len(input logic [1:0] code);
        logic [8:0] m;
        case (code)
            2'h0: m = light_adc_pkg::MULT_SHORT;
            2'h1: m = light_adc_pkg::MULT_MID;
            default: m = light_adc_pkg::MULT_LONG;
        endcase
        period_len = 19'(m * PERIOD_UNIT);
    endfunction : period_len

    // ------------------------------------------------------------
    // Pin synchronisers on mclk
    // ------------------------------------------------------------
    logic [1:0] scl_s, sda_s, sel_s0, sel_s1;
    logic [6:0] own_addr;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            sel_s0 <= 2'h0;
            sel_s1 <= 2'h0;
        end else begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            sel_s0 <= addr_sel;
            sel_s1 <= sel_s0;
        end
    end

    always_comb begin
        case (sel_s1)
            light_adc_pkg::SEL_GND: own_addr = light_adc_pkg::ADDR_GND;
            light_adc_pkg::SEL_VDD: own_addr = light_adc_pkg::ADDR_VDD;
            default: own_addr = light_adc_pkg::ADDR_FLOAT;
        endcase
    end

    // ------------------------------------------------------------
    // Bus target
    // ------------------------------------------------------------
    light_adc_pkg::bus_event_t ev;
    logic [7:0] rd_byte;
    logic link_oe;

    i2c_target_link u_link (
        .mclk(mclk),
        .rst_b(rst_b),
        .scl(scl_s[1]),
        .sda(sda_s[1]),
        .own_addr(own_addr),
        .rd_byte(rd_byte),
        .ev(ev),
        .sda_oe(link_oe)
    );

    // Open drain: only ever pull low
    assign sda_oe = link_oe;

    // ------------------------------------------------------------
    // Register file on mclk
    // ------------------------------------------------------------
    logic [3:0] ptr, next_ptr;
    logic word, next_word;
    logic [7:0] power_reg, next_power_reg, timing_reg, next_timing_reg;
    logic [7:0] thr [2:6];
    logic [7:0] next_thr [2:6];
    logic [7:0] hi_shadow, next_hi_shadow;
    light_adc_pkg::results_t data_reg, next_data_reg;
    logic [2:0] done_s, next_done_s;
    light_adc_pkg::results_t hold;
    logic hold_tgl_osc, next_hold_tgl;
    logic next_powered;

    always_comb begin
        case (ptr)
            light_adc_pkg::PTR_POWER: rd_byte = power_reg;
            light_adc_pkg::PTR_TIMING: rd_byte = timing_reg;
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6: rd_byte = thr[ptr];
            light_adc_pkg::PTR_ID: rd_byte = light_adc_pkg::ID_VALUE;
            light_adc_pkg::PTR_BB_LO: rd_byte = data_reg.broadband_channel[7:0];
            light_adc_pkg::PTR_IR_LO: rd_byte = data_reg.infrared_channel[7:0];
            light_adc_pkg::PTR_BB_HI, light_adc_pkg::PTR_IR_HI: rd_byte = hi_shadow;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_ptr = ptr;
        next_word = word;
        next_power_reg = power_reg;
        next_timing_reg = timing_reg;
        next_thr = thr;
        next_hi_shadow = hi_shadow;
        next_data_reg = data_reg;
        next_done_s = {done_s[1:0], hold_tgl_osc};
        // Toggle edge means a stable new result sits in the hold
        if (done_s[2] != done_s[1]) next_data_reg = hold;
        // High bytes track live data under byte access; under word access they hold the low byte read's snapshot
        if (ptr == light_adc_pkg::PTR_BB_HI && !word)
            next_hi_shadow = data_reg.broadband_channel[15:8];
        if (ptr == light_adc_pkg::PTR_IR_HI && !word)
            next_hi_shadow = data_reg.infrared_channel[15:8];
        if (ev.wr_stb) begin
            if (ev.wr_byte[light_adc_pkg::CMD_FLAG_BIT]) begin
                next_ptr = ev.wr_byte[3:0];
                next_word = ev.wr_byte[light_adc_pkg::CMD_WORD_BIT];
                // Clear bit is not stored: no interrupt logic here
            end else begin
                case (ptr)
                    light_adc_pkg::PTR_POWER: next_power_reg = {6'h00, ev.wr_byte[1:0]};
                    light_adc_pkg::PTR_TIMING: next_timing_reg = ev.wr_byte;
                    4'h2, 4'h3, 4'h4, 4'h5, 4'h6: next_thr[ptr] = ev.wr_byte;
                    default: next_power_reg = power_reg;
                endcase
                if (word) next_ptr = ptr + 4'h1;
            end
        end
        if (ev.rd_stb) begin
            // Low byte read snapshots the high half for a coherent word
            if (ptr == light_adc_pkg::PTR_BB_LO)
                next_hi_shadow = data_reg.broadband_channel[15:8];
            if (ptr == light_adc_pkg::PTR_IR_LO)
                next_hi_shadow = data_reg.infrared_channel[15:8];
            if (word) next_ptr = ptr + 4'h1;
        end
        next_powered = (power_reg[1:0] == light_adc_pkg::POWER_ON);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= 4'h0;
            word <= 1'b0;
            power_reg <= light_adc_pkg::POWER_RESET;
            timing_reg <= light_adc_pkg::TIMING_RESET;
            for (int i = 2; i <= 6; i++) thr[i] <= 8'h00;
            hi_shadow <= 8'h00;
            data_reg <= '0;
            done_s <= 3'h0;
            powered <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            ptr <= next_ptr;
            word <= next_word;
            power_reg <= next_power_reg;
            timing_reg <= next_timing_reg;
            thr <= next_thr;
            hi_shadow <= next_hi_shadow;
            data_reg <= next_data_reg;
            done_s <= next_done_s;
            powered <= next_powered;
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Oscillator domain: control sync and pulse sync
    // ------------------------------------------------------------
    // Control bits are quasi-static, so a two-flop level sync suffices
    logic [3:0] ctl_s0, ctl_s1;
    logic [1:0] bb_s, ir_s;
    logic man_d;

    always_ff @(posedge osc_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_s0 <= 4'h0;
            ctl_s1 <= 4'h0;
            bb_s <= 2'h0;
            ir_s <= 2'h0;
            man_d <= 1'b0;
        end else begin
            ctl_s0 <= {powered, timing_reg[light_adc_pkg::MANUAL_BIT], timing_reg[1:0]};
            ctl_s1 <= ctl_s0;
            bb_s <= {bb_s[0], broadband_pulse};
            ir_s <= {ir_s[0], infrared_pulse};
            man_d <= ctl_s1[2];
        end
    end

    // ------------------------------------------------------------
    // Oscillator domain: integration
    // ------------------------------------------------------------
    logic [18:0] cyc, next_cyc;
    logic [15:0] bb_cnt, ir_cnt, next_bb_cnt, next_ir_cnt;
    light_adc_pkg::results_t next_hold;
    logic manual_mode, run, finish, slot;

    assign manual_mode = (ctl_s1[1:0] == light_adc_pkg::INTEG_MANUAL);
    assign run = ctl_s1[3] && (!manual_mode || ctl_s1[2]);
    // Compare with >= so a switch to a shorter period never leaves cyc stranded
    assign finish = manual_mode ? (man_d && !ctl_s1[2])
                                : (cyc >= period_len(ctl_s1[1:0]) - 19'd1);
    assign slot = (cyc >= light_adc_pkg::OFFSET_CYCLES) && !cyc[0];

    always_comb begin
        next_cyc = cyc;
        next_bb_cnt = bb_cnt;
        next_ir_cnt = ir_cnt;
        next_hold = hold;
        next_hold_tgl = hold_tgl_osc;
        if (!ctl_s1[3]) begin
            next_cyc = 19'd0;
            next_bb_cnt = 16'h0000;
            next_ir_cnt = 16'h0000;
        end else if (finish && (cyc != 19'd0 || !manual_mode)) begin
            next_hold.broadband_channel = bb_cnt;
            next_hold.infrared_channel = ir_cnt;
            next_hold_tgl = ~hold_tgl_osc;
            next_cyc = 19'd0;
            next_bb_cnt = 16'h0000;
            next_ir_cnt = 16'h0000;
        end else if (run) begin
            if (cyc != 19'h7FFFF) next_cyc = cyc + 19'd1;
            next_bb_cnt = sat_inc(bb_cnt, slot && bb_s[1]);
            next_ir_cnt = sat_inc(ir_cnt, slot && ir_s[1]);
        end
    end

    always_ff @(posedge osc_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc <= 19'd0;
            bb_cnt <= 16'h0000;
            ir_cnt <= 16'h0000;
            hold <= '0;
            hold_tgl_osc <= 1'b0;
        end else begin
            cyc <= next_cyc;
            bb_cnt <= next_bb_cnt;
            ir_cnt <= next_ir_cnt;
            hold <= next_hold;
            hold_tgl_osc <= next_hold_tgl;
        end
    end
endmodule : light_adc_core
`default_nettype wire

// file: design/light_adc_pkg.sv
/*
 Shared constants and carrier types of the two-channel light sensor core.
 Assumes a 50 MHz system clock and a separate integration oscillator.
*/
package light_adc_pkg;
    // ------------------------------------------------------------
    // Integration timing
    // ------------------------------------------------------------
    localparam int unsigned PERIOD_UNIT = 918;
    localparam logic [8:0] MULT_SHORT = 9'd11;
    localparam logic [8:0] MULT_MID = 9'd81;
    localparam logic [8:0] MULT_LONG = 9'd322;
    localparam logic [18:0] OFFSET_CYCLES = 19'd4;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // ------------------------------------------------------------
    // Register pointers and fields
    // ------------------------------------------------------------
    localparam logic [3:0] PTR_POWER = 4'h0;
    localparam logic [3:0] PTR_TIMING = 4'h1;
    localparam logic [3:0] PTR_IRQ_CTRL = 4'h6;
    localparam logic [3:0] PTR_ID = 4'hA;
    localparam logic [3:0] PTR_BB_LO = 4'hC;
    localparam logic [3:0] PTR_BB_HI = 4'hD;
    localparam logic [3:0] PTR_IR_LO = 4'hE;
    localparam logic [3:0] PTR_IR_HI = 4'hF;
    localparam int CMD_FLAG_BIT = 7;
    localparam int CMD_CLEAR_BIT = 6;
    localparam int CMD_WORD_BIT = 5;
    localparam int MANUAL_BIT = 3;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [1:0] POWER_ON = 2'h3;
    localparam logic [7:0] TIMING_RESET = 8'h02;
    localparam logic [1:0] INTEG_MANUAL = 2'h3;
    // Identity value is arbitrary
    localparam logic [7:0] ID_VALUE = 8'h5A;
    // ------------------------------------------------------------
    // Bus addresses by select pin level
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_GND = 7'h29;
    localparam logic [6:0] ADDR_FLOAT = 7'h39;
    localparam logic [6:0] ADDR_VDD = 7'h49;
    typedef enum logic [1:0] {
        SEL_GND = 2'h0,
        SEL_FLOAT = 2'h1,
        SEL_VDD = 2'h2
    } addr_sel_t;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_stb;
        logic [7:0] wr_byte;
        logic rd_stb;
    } bus_event_t;
    typedef struct packed {
        logic [15:0] broadband_channel;
        logic [15:0] infrared_channel;
    } results_t;
endpackage : light_adc_pkg

// file: design/i2c_target_link.sv
/*
 Byte level two-wire bus target, sampled on the system clock.
 Assumes scl and sda arrive already synchronised to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_target_link (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] own_addr,
    input wire logic [7:0] rd_byte,
    output light_adc_pkg::bus_event_t ev,
    output logic sda_oe
);
    typedef enum logic [5:0] {
        IDLE = 6'b000001,
        ADDR = 6'b000010,
        AACK = 6'b000100,
        WRITE = 6'b001000,
        WACK = 6'b010000,
        READ = 6'b100000
    } link_state_t;

    link_state_t state, next_state;
    logic scl_d, sda_d, next_scl_d, next_sda_d;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic rd_dir, next_rd_dir, next_oe;
    light_adc_pkg::bus_event_t next_ev;
    logic rise, fall, start, stop;

    assign rise = scl & ~scl_d;
    assign fall = ~scl & scl_d;
    assign start = scl & scl_d & sda_d & ~sda;
    assign stop = scl & scl_d & ~sda_d & sda;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_rd_dir = rd_dir;
        next_oe = sda_oe;
        next_ev = '0;
        next_scl_d = scl;
        next_sda_d = sda;
        if (start) begin
            next_state = ADDR;
            next_cnt = 4'h0;
            next_oe = 1'b0;
        end else if (stop) begin
            next_state = IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                IDLE: next_oe = 1'b0;
                ADDR, WRITE: begin
                    if (rise) begin
                        next_shift = {shift[6:0], sda};
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        // Silent on a foreign address
                        if (state == WRITE || shift[7:1] == own_addr) begin
                            next_oe = 1'b1;
                            next_state = (state == ADDR) ? AACK : WACK;
                            next_rd_dir = (state == ADDR) ? shift[0] : rd_dir;
                            next_ev.wr_stb = (state == WRITE);
                            next_ev.wr_byte = shift;
                        end else begin
                            next_state = IDLE;
                        end
                    end
                end
                AACK, WACK: begin
                    if (fall) begin
                        next_cnt = 4'h0;
                        if (rd_dir && state == AACK) begin
                            next_state = READ;
                            next_oe = ~rd_byte[7];
                            next_shift = {rd_byte[6:0], 1'b0};
                            next_ev.rd_stb = 1'b1;
                        end else begin
                            next_state = WRITE;
                            next_oe = 1'b0;
                        end
                    end
                end
                READ: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                        // Ninth bit: master ack keeps the burst going
                        if (cnt == 4'h8 && sda) next_state = IDLE;
                    end else if (fall) begin
                        if (cnt == 4'h8) begin
                            next_oe = 1'b0;
                        end else if (cnt == 4'h9) begin
                            next_cnt = 4'h0;
                            next_oe = ~rd_byte[7];
                            next_shift = {rd_byte[6:0], 1'b0};
                            next_ev.rd_stb = 1'b1;
                        end else begin
                            next_oe = ~shift[7];
                            next_shift = {shift[6:0], 1'b0};
                        end
                    end
                end
                default: next_state = IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            rd_dir <= 1'b0;
            sda_oe <= 1'b0;
            ev <= '0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            rd_dir <= next_rd_dir;
            sda_oe <= next_oe;
            ev <= next_ev;
            scl_d <= next_scl_d;
            sda_d <= next_sda_d;
        end
    end
endmodule : i2c_target_link
`default_nettype wire

// file: verification/light_adc_assertions.sv
/*
 Pin level checks of the light sensor core, bound to its top module.
 Assumes bench bus clock phases of 32 mclk and a quiet bus around resets.
*/
`timescale 1ns/1ps
`default_nettype none
module light_adc_assertions #(
    parameter int unsigned PERIOD_UNIT = 918
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic osc_clk,
    input wire logic broadband_pulse,
    input wire logic infrared_pulse,
    input wire logic [1:0] addr_sel,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic powered
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [9:0] oe_cnt;
    logic [7:0] idle_cnt;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oe_cnt <= 10'h000;
            idle_cnt <= 8'h00;
        end else begin
            oe_cnt <= sda_oe ? oe_cnt + 10'h001 : 10'h000;
            idle_cnt <= !scl_in ? 8'h00 : (idle_cnt == 8'hFF ? idle_cnt : idle_cnt + 8'h01);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    reset_release_a: assert property ($rose(rst_b) |-> !sda_oe && !powered)
        else $error("pins active right after reset");
    sda_out_low_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data pin driven high");
    oe_rise_scl_a: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 10))
        else $error("drive began away from a clock fall");
    oe_fall_scl_a: assert property ($fell(sda_oe) |-> !scl_in && $past(scl_in, 10))
        else $error("release away from a clock fall");
    oe_min_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("drive dropped too soon");
    oe_max_hold_a: assert property (oe_cnt < 10'h258)
        else $error("drive held past one byte");
    idle_silent_a: assert property (idle_cnt > 8'h50 |-> !sda_oe)
        else $error("drive on an idle bus");
    idle_power_a: assert property (idle_cnt > 8'h50 |-> $stable(powered))
        else $error("power changed without a bus write");
    cover property ($rose(sda_oe));
    cover property ($rose(powered));
    cover property ($fell(powered));
endmodule : light_adc_assertions
bind light_adc_core light_adc_assertions #(.PERIOD_UNIT(PERIOD_UNIT)) chk (
    .mclk(mclk), .rst_b(rst_b), .osc_clk(osc_clk), .broadband_pulse(broadband_pulse),
    .infrared_pulse(infrared_pulse), .addr_sel(addr_sel), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .powered(powered)
);
`default_nettype wire

// file: verification/i2c_master_model.sv
/*
 Behavioural two-wire bus master driving the core's pins.
 Assumes a pulled-up data wire resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic mclk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    // Faster than the bus rating to keep the run short; the core samples on mclk
    localparam int HALF = 32;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge mclk);
    endtask : pause
    task automatic start_cond;
        if (!scl) begin
            pause(4);
            sda_low = 1'b0;
            pause(HALF);
            scl = 1'b1;
        end
        pause(HALF);
        sda_low = 1'b1;
        pause(HALF);
        scl = 1'b0;
    endtask : start_cond
    task automatic clock_bit(input logic b, output logic seen);
        // Data moves a few cycles after the fall, never alongside it
        pause(4);
        sda_low = !b;
        pause(HALF - 4);
        scl = 1'b1;
        pause(HALF);
        seen = sda_line;
        scl = 1'b0;
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] b, output logic nack);
        logic seen;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], seen);
        clock_bit(1'b1, nack);
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, seen);
            b[i] = seen;
        end
        clock_bit(last, seen);
    endtask : recv_byte
    task automatic stop_cond;
        pause(4);
        sda_low = 1'b1;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        sda_low = 1'b0;
        pause(HALF);
    endtask : stop_cond
endmodule : i2c_master_model
`default_nettype wire

// file: verification/light_adc_core_tb.sv
/*
 Self-checking bench of the light sensor core with a bus master model.
 Assumes free-running oscillator and comparator levels held high or low.
*/
`timescale 1ns/1ps
`default_nettype none
module light_adc_core_tb;
    localparam int unsigned UNIT = 4;
    localparam logic [15:0] SHORT_EXP = 16'(int'(light_adc_pkg::MULT_SHORT) * UNIT / 2 - 2);
    typedef struct packed {
        logic [3:0] ptr;
        logic wr;
        logic [7:0] data;
        logic [7:0] exp;
    } row_t;
    row_t rows [5] = '{'{4'h1, 1'b0, 8'h00, 8'h02}, '{4'h3, 1'b1, 8'h3C, 8'h3C},
        '{4'h2, 1'b1, 8'h7F, 8'h7F}, '{4'h1, 1'b1, 8'h00, 8'h00}, '{4'h0, 1'b1, 8'h03, 8'h03}};
    logic [6:0] addr_tab [3] = '{light_adc_pkg::ADDR_GND, light_adc_pkg::ADDR_FLOAT,
        light_adc_pkg::ADDR_VDD};
    logic [8:0] mult_tab [3] = '{light_adc_pkg::MULT_SHORT, light_adc_pkg::MULT_MID,
        light_adc_pkg::MULT_LONG};
    logic mclk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst_b = 1'b0;
    logic bb = 1'b1;
    logic ir = 1'b1;
    logic [1:0] addr_sel = 2'h0;
    logic [6:0] cur_addr = light_adc_pkg::ADDR_GND;
    logic scl, sda_low, sda_out, sda_oe, powered, sda, nack;
    logic [31:0] d;
    int n;
    int error_cnt = 0;
    int checked = 0;
    assign sda = !(sda_low || sda_oe);
    always #10 mclk = ~mclk;
    initial begin
        #7;
        forever #24 osc_clk = ~osc_clk;
    end
    i2c_master_model master (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
    light_adc_core #(.PERIOD_UNIT(UNIT)) dut (.mclk(mclk), .rst_b(rst_b), .osc_clk(osc_clk),
        .broadband_pulse(bb), .infrared_pulse(ir), .addr_sel(addr_sel), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .powered(powered));
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask : check
    task automatic send(input logic [7:0] b);
        logic k;
        master.send_byte(b, k);
        check("ack", 16'h0000, {15'h0000, k});
    endtask : send
    task automatic send_cmd(input logic [7:0] c);
        master.start_cond();
        send({cur_addr, 1'b0});
        send(c);
        master.stop_cond();
    endtask : send_cmd
    task automatic write_reg(input logic [3:0] ptr, input logic [7:0] v);
        master.start_cond();
        send({cur_addr, 1'b0});
        send({4'h8, ptr});
        send(v);
        master.stop_cond();
    endtask : write_reg
    task automatic read_bytes(input int cnt, output logic [31:0] v);
        logic [7:0] b;
        v = 32'h00000000;
        master.start_cond();
        send({cur_addr, 1'b1});
        for (int i = 0; i < cnt; i++) begin
            master.recv_byte(i == cnt - 1, b);
            v[8*i +: 8] = b;
        end
        master.stop_cond();
    endtask : read_bytes
    task automatic results(input logic [15:0] eb, input logic [15:0] ei);
        logic [31:0] v;
        send_cmd(8'hAC);
        read_bytes(4, v);
        check("broadband", eb, v[15:0]);
        check("infrared", ei, v[31:16]);
    endtask : results
    task automatic test_done;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (95000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        for (int r = 0; r < 5; r++) begin
            if (rows[r].wr) write_reg(rows[r].ptr, rows[r].data);
            send_cmd({4'h8, rows[r].ptr});
            read_bytes(1, d);
            check("register", {8'h00, rows[r].exp}, d[15:0]);
        end
        check("powered", 16'h0001, {15'h0000, powered});
        for (int s = 0; s < 3; s++) begin
            addr_sel = s[1:0];
            cur_addr = addr_tab[s];
            repeat (4) @(negedge mclk);
            send_cmd(8'h80);
        end
        addr_sel = 2'h0;
        cur_addr = light_adc_pkg::ADDR_GND;
        repeat (4) @(negedge mclk);
        master.start_cond();
        master.send_byte({light_adc_pkg::ADDR_FLOAT, 1'b0}, nack);
        check("foreign ack", 16'h0001, {15'h0000, nack});
        master.stop_cond();
        for (int k = 0; k < 3; k++) begin
            write_reg(light_adc_pkg::PTR_TIMING, {6'h00, k[1:0]});
            n = int'(mult_tab[k]) * UNIT;
            repeat (n * 6 + 300) @(negedge mclk);
            results(16'(n / 2 - 2), 16'(n / 2 - 2));
        end
        write_reg(light_adc_pkg::PTR_TIMING, 8'h00);
        ir = 1'b0;
        repeat (8000) @(negedge mclk);
        results(SHORT_EXP, 16'h0000);
        write_reg(4'h3, 8'h90);
        read_bytes(1, d);
        check("pointer", 16'h0003, d[15:0]);
        write_reg(light_adc_pkg::PTR_POWER, 8'h00);
        check("powered", 16'h0000, {15'h0000, powered});
        ir = 1'b1;
        repeat (900) @(negedge mclk);
        results(SHORT_EXP, 16'h0000);
        write_reg(light_adc_pkg::PTR_POWER, 8'h03);
        repeat (900) @(negedge mclk);
        results(SHORT_EXP, SHORT_EXP);
        rst_b = 1'b0;
        repeat (8) @(negedge mclk);
        check("reset drive", 16'h0000, {15'h0000, sda_oe});
        check("reset power", 16'h0000, {15'h0000, powered});
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        send_cmd({4'hC, light_adc_pkg::PTR_TIMING});
        read_bytes(1, d);
        check("timing", {8'h00, light_adc_pkg::TIMING_RESET}, d[15:0]);
        test_done();
    end
endmodule : light_adc_core_tb
`default_nettype wire
